// [rtl/unrem_pkg.sv]
package unrem_pkg;

  // Register and bus geometry.
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int REG_W = 16;
  localparam int EP_N = 3;
  localparam int HI_LSB = 4;
  localparam int LO_LSB = 0;

  // Printed offsets are register indices; the byte address is four times the index.
  localparam logic [31:0] IDX_RX_EVENT = 32'h5000_1818;
  localparam logic [31:0] IDX_RX_MASK = 32'h5000_181A;
  localparam logic [31:0] IDX_NAK_EVENT = 32'h5000_181C;
  localparam logic [31:0] IDX_NAK_MASK = 32'h5000_181E;
  localparam logic [31:0] IDX_IRQ_STATUS = 32'h5000_1830;
  localparam logic [31:0] IDX_IRQ_MASK = 32'h5000_1832;

  // Only the low address bits are decoded, so the block aliases across the rest of the space.
  localparam logic [ADDR_W-1:0] ADR_RX_EVENT = {IDX_RX_EVENT[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADR_RX_MASK = {IDX_RX_MASK[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADR_NAK_EVENT = {IDX_NAK_EVENT[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADR_NAK_MASK = {IDX_NAK_MASK[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADR_IRQ_STATUS = {IDX_IRQ_STATUS[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADR_IRQ_MASK = {IDX_IRQ_MASK[ADDR_W-3:0], 2'h0};

  // Reset values and writable field masks.
  localparam logic [REG_W-1:0] RST_REG = 16'h0000;
  localparam logic [REG_W-1:0] EV_FIELDS = 16'h0077;
  localparam logic [REG_W-1:0] IRQ_FIELDS = 16'h0003;
  localparam logic [EP_N-1:0] RST_EP = 3'h0;

  // Interrupt status bit positions.
  localparam int IRQ_W = 2;
  localparam int IRQ_RX = 0;
  localparam int IRQ_NAK = 1;
  localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

  // Endpoint number carried by bit 0 of every three-bit field.
  localparam logic [1:0] EP_BASE = 2'h1;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

endpackage

// [rtl/unrem_evbank.sv]
`timescale 1ns/1ps
// Sticky flag bank; a set in the same cycle as a clear wins.
module unrem_evbank
  import unrem_pkg::*;
#(
  parameter int W = 3
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Set and clear strobes.
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Flag state.
  output logic [W-1:0] flags_q
);

  logic [W-1:0] flags_d;

  assign flags_d = (flags_q & ~clr) | set;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule

// [rtl/unrem_masksum.sv]
`timescale 1ns/1ps
// Reduces one register image against its mask into a single summary term.
module unrem_masksum
  import unrem_pkg::*;
(
  // Event fields.
  input wire logic [EP_N-1:0] ev_hi,
  input wire logic [EP_N-1:0] ev_lo,
  // Mask image.
  input wire logic [REG_W-1:0] mask,
  // Summary.
  output logic hit
);

  logic [EP_N-1:0] hi_hit;
  logic [EP_N-1:0] lo_hit;

  assign hi_hit = ev_hi & mask[HI_LSB +: EP_N];
  assign lo_hit = ev_lo & mask[LO_LSB +: EP_N];
  assign hit = (|hi_hit) | (|lo_hit);

endmodule

// [rtl/unrem_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - Unmasked overrun events raise receive summary flag.
// - Unmasked receive FIFO events raise receive summary.
// - OUT NAK latches when address and endpoint enabled.
// - OUT NAK caused by overrun latches nothing.
// - IN NAK latches when address and endpoint enabled.
// - Reading NAK event register clears its bits.
// - Unmasked OUT NAK events raise NAK summary.
// - Unmasked IN NAK events raise NAK summary.
// - FIFO overrun sets bit; receive-event read clears.
module unrem_top
  import unrem_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // AXI4-Lite write address.
  input wire logic [DATA_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [DATA_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Enables from the function address and endpoint control registers.
  input wire logic addr_enable,
  input wire logic [EP_N-1:0] endpoint_enable,
  // NAK handshake report from the protocol engine.
  input wire logic nak_sent,
  input wire logic nak_token_in,
  input wire logic [1:0] nak_endpoint,
  input wire logic nak_for_overrun,
  // Receive FIFO events from the protocol engine.
  input wire logic [EP_N-1:0] rx_overrun_pulse,
  input wire logic [EP_N-1:0] rx_fifo_event,
  // Summary flags toward the main event register, and the interrupt.
  output logic receive_summary_flag_q,
  output logic nak_summary_flag_q,
  output logic irq_q
);

  // Byte-lane merge of a write into a 16-bit register image.
  function automatic logic [REG_W-1:0] wmerge(input logic [REG_W-1:0] old, input logic [DATA_W-1:0] data,
                                              input logic [3:0] strb);
    logic [REG_W-1:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // Register decode on the low address bits.
  function automatic logic is_reg(input logic [DATA_W-1:0] addr, input logic [ADDR_W-1:0] adr);
    return addr[ADDR_W-1:0] == adr;
  endfunction

  // Bus state.
  logic aw_ok_q;
  logic aw_ok_d;
  logic w_ok_q;
  logic w_ok_d;
  logic [DATA_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_d;
  logic wready_d;
  logic bvalid_d;
  logic [1:0] bresp_d;
  logic arready_d;
  logic rvalid_d;
  logic [DATA_W-1:0] rdata_d;
  logic [1:0] rresp_d;

  // Register state.
  logic [REG_W-1:0] rx_mask_q;
  logic [REG_W-1:0] rx_mask_d;
  logic [REG_W-1:0] nak_mask_q;
  logic [REG_W-1:0] nak_mask_d;
  logic [REG_W-1:0] irq_mask_q;
  logic [REG_W-1:0] irq_mask_d;
  logic [EP_N-1:0] rx_fifo_q;
  logic [EP_N-1:0] ovr_q;
  logic [EP_N-1:0] out_nak_q;
  logic [EP_N-1:0] in_nak_q;
  logic [IRQ_W-1:0] irq_stat_q;

  // Handshakes and decode.
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_go;
  logic wr_rx_mask;
  logic wr_nak_mask;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic wr_hit;
  logic rd_rx_event;
  logic rd_rx_mask;
  logic rd_nak_event;
  logic rd_nak_mask;
  logic rd_irq_stat;
  logic rd_irq_mask;
  logic rd_hit;
  logic [REG_W-1:0] rd_word;

  // Event sources.
  logic [EP_N-1:0] nak_ep_hit;
  logic [EP_N-1:0] out_nak_set;
  logic [EP_N-1:0] in_nak_set;
  logic [EP_N-1:0] ovr_clr;
  logic [EP_N-1:0] nak_clr;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic rx_sum_d;
  logic nak_sum_d;
  logic irq_d;

  // Write channel: address and data are taken independently and held until both are in.
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_go = aw_ok_q & w_ok_q & ~s_axi_bvalid;
  assign aw_ok_d = (aw_ok_q | aw_take) & ~wr_go;
  assign w_ok_d = (w_ok_q | w_take) & ~wr_go;
  assign bvalid_d = wr_go | (s_axi_bvalid & ~s_axi_bready);
  assign awready_d = ~aw_ok_d & ~bvalid_d;
  assign wready_d = ~w_ok_d & ~bvalid_d;

  assign wr_rx_mask = wr_go & is_reg(awaddr_q, ADR_RX_MASK);
  assign wr_nak_mask = wr_go & is_reg(awaddr_q, ADR_NAK_MASK);
  assign wr_irq_stat = wr_go & is_reg(awaddr_q, ADR_IRQ_STATUS);
  assign wr_irq_mask = wr_go & is_reg(awaddr_q, ADR_IRQ_MASK);
  // The event registers are read-only, so a write to them is answered with an error.
  assign wr_hit = is_reg(awaddr_q, ADR_RX_MASK) | is_reg(awaddr_q, ADR_NAK_MASK) |
                  is_reg(awaddr_q, ADR_IRQ_STATUS) | is_reg(awaddr_q, ADR_IRQ_MASK);
  assign bresp_d = wr_go ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : s_axi_bresp;

  assign rx_mask_d = wr_rx_mask ? (wmerge(rx_mask_q, wdata_q, wstrb_q) & EV_FIELDS)
                                : rx_mask_q;
  assign nak_mask_d = wr_nak_mask ? (wmerge(nak_mask_q, wdata_q, wstrb_q) & EV_FIELDS) : nak_mask_q;
  assign irq_mask_d = wr_irq_mask ? (wmerge(irq_mask_q, wdata_q, wstrb_q) & IRQ_FIELDS) : irq_mask_q;

  // Read channel: one read at a time, answered on the cycle after the address is taken.
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
  assign arready_d = ~rvalid_d;

  assign rd_rx_event = ar_take & is_reg(s_axi_araddr, ADR_RX_EVENT);
  assign rd_rx_mask = is_reg(s_axi_araddr, ADR_RX_MASK);
  assign rd_nak_event = ar_take & is_reg(s_axi_araddr, ADR_NAK_EVENT);
  assign rd_nak_mask = is_reg(s_axi_araddr, ADR_NAK_MASK);
  assign rd_irq_stat = is_reg(s_axi_araddr, ADR_IRQ_STATUS);
  assign rd_irq_mask = is_reg(s_axi_araddr, ADR_IRQ_MASK);
  assign rd_hit = is_reg(s_axi_araddr, ADR_RX_EVENT) | rd_rx_mask | is_reg(s_axi_araddr, ADR_NAK_EVENT) |
                  rd_nak_mask | rd_irq_stat | rd_irq_mask;

  assign rd_word = rd_rx_event ? {9'h000, ovr_q, 1'b0, rx_fifo_q} :
                   rd_rx_mask ? rx_mask_q :
                   rd_nak_event ? {9'h000, out_nak_q, 1'b0, in_nak_q} :
                   rd_nak_mask ? nak_mask_q :
                   rd_irq_stat ? {14'h0000, irq_stat_q} :
                   rd_irq_mask ? irq_mask_q : RST_REG;
  assign rdata_d = ar_take ? {16'h0000, rd_word} : s_axi_rdata;
  assign rresp_d = ar_take ? (rd_hit ? RESP_OKAY : RESP_SLVERR) : s_axi_rresp;

  // Endpoint decode: bit i of every field stands for endpoint i+1.
  genvar gi;
  generate
    for (gi = 0; gi < EP_N; gi++) begin : g_ep
      assign nak_ep_hit[gi] = nak_sent & addr_enable & endpoint_enable[gi] &
                              (nak_endpoint == EP_BASE + 2'(gi));
      assign out_nak_set[gi] = nak_ep_hit[gi] & ~nak_token_in & ~nak_for_overrun;
      assign in_nak_set[gi] = nak_ep_hit[gi] & nak_token_in;
    end
  endgenerate

  // A read snapshots the bits and clears them; an event in that same cycle survives for the next read.
  assign ovr_clr = {EP_N{rd_rx_event}};
  assign nak_clr = {EP_N{rd_nak_event}};

  unrem_evbank #(
    .W(EP_N)
  ) u_ovr (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .set(rx_overrun_pulse),
    .clr(ovr_clr),
    .flags_q(ovr_q)
  );

  unrem_evbank #(
    .W(EP_N)
  ) u_out_nak (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .set(out_nak_set),
    .clr(nak_clr),
    .flags_q(out_nak_q)
  );

  unrem_evbank #(
    .W(EP_N)
  ) u_in_nak (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .set(in_nak_set),
    .clr(nak_clr),
    .flags_q(in_nak_q)
  );

  // Summary flags follow the masked events one cycle later.
  unrem_masksum u_rx_sum (
    .ev_hi(ovr_q),
    .ev_lo(rx_fifo_q),
    .mask(rx_mask_q),
    .hit(rx_sum_d)
  );

  unrem_masksum u_nak_sum (
    .ev_hi(out_nak_q),
    .ev_lo(in_nak_q),
    .mask(nak_mask_q),
    .hit(nak_sum_d)
  );

  // Interrupt status is sticky while a summary flag stands, and cleared by writing ones.
  assign irq_set[IRQ_RX] = receive_summary_flag_q;
  assign irq_set[IRQ_NAK] = nak_summary_flag_q;
  assign irq_clr = wr_irq_stat ? (wdata_q[IRQ_W-1:0] & {IRQ_W{wstrb_q[0]}}) : RST_IRQ;

  unrem_evbank #(
    .W(IRQ_W)
  ) u_irq_stat (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .set(irq_set),
    .clr(irq_clr),
    .flags_q(irq_stat_q)
  );

  assign irq_d = |(irq_stat_q & irq_mask_q[IRQ_W-1:0]);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_ok_q <= aw_ok_d;
      w_ok_q <= w_ok_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      awaddr_q <= RD_ZERO;
      wdata_q <= RD_ZERO;
      wstrb_q <= 4'h0;
    end else begin
      awaddr_q <= aw_take ? s_axi_awaddr : awaddr_q;
      wdata_q <= w_take ? s_axi_wdata : wdata_q;
      wstrb_q <= w_take ? s_axi_wstrb : wstrb_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RD_ZERO;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
    end
  end

  // The FIFO event bits are copies of state owned by the receive status logic, so they are only sampled.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_mask_q <= RST_REG;
      nak_mask_q <= RST_REG;
      irq_mask_q <= RST_REG;
      rx_fifo_q <= RST_EP;
    end else begin
      rx_mask_q <= rx_mask_d;
      nak_mask_q <= nak_mask_d;
      irq_mask_q <= irq_mask_d;
      rx_fifo_q <= rx_fifo_event;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      receive_summary_flag_q <= 1'b0;
      nak_summary_flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      receive_summary_flag_q <= rx_sum_d;
      nak_summary_flag_q <= nak_sum_d;
      irq_q <= irq_d;
    end
  end

endmodule

// [tb/unrem_assertions.sv]
`timescale 1ns/1ps
module unrem_assertions
  import unrem_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Bus handshakes.
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flags.
  input wire logic receive_summary_flag_q,
  input wire logic nak_summary_flag_q,
  input wire logic irq_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_SLV_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == RD_ZERO)
    else $error("refused read carries data");
  AST_RSV_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == '0 && !s_axi_rdata[3])
    else $error("reserved bits not zero");
  AST_MASK_RST: assert property ($fell(sys_rst) |-> (!receive_summary_flag_q && !nak_summary_flag_q)[*2])
    else $error("flag raised with cleared masks");
  cover property (nak_summary_flag_q);
  cover property (receive_summary_flag_q);
  cover property (irq_q);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

bind unrem_top unrem_assertions unrem_assertions_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_q(irq_q),
  .receive_summary_flag_q(receive_summary_flag_q), .nak_summary_flag_q(nak_summary_flag_q));

// [tb/unrem_host_model.sv]
`timescale 1ns/1ps
module unrem_host_model
  import unrem_pkg::*;
(
  // Clock.
  input wire logic clk_sys,
  // Reports toward the block.
  output logic nak_sent = 1'b0,
  output logic nak_token_in = 1'b0,
  output logic [1:0] nak_endpoint = 2'h0,
  output logic nak_for_overrun = 1'b0,
  output logic [EP_N-1:0] rx_overrun_pulse = 3'h0
);
  // Qualifiers are inverted between pulses so a stale value is never taken for a report.
  task automatic nak(input logic tin, input logic [1:0] ep, input logic ovr);
    @(posedge clk_sys);
    nak_sent <= 1'b1;
    nak_token_in <= tin;
    nak_endpoint <= ep;
    nak_for_overrun <= ovr;
    @(posedge clk_sys);
    nak_sent <= 1'b0;
    nak_token_in <= ~tin;
    nak_endpoint <= ~ep;
    nak_for_overrun <= ~ovr;
  endtask
  task automatic overrun(input logic [EP_N-1:0] m);
    @(posedge clk_sys);
    rx_overrun_pulse <= m;
    @(posedge clk_sys);
    rx_overrun_pulse <= 3'h0;
  endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; $display("Error %0t got %h exp %h", $time, g, e); end end
module tb
  import unrem_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [DATA_W-1:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_q;
  logic nak_sent, nak_token_in, nak_for_overrun, receive_summary_flag_q, nak_summary_flag_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, nak_endpoint, rsp;
  logic addr_enable = 1'b0;
  logic [EP_N-1:0] endpoint_enable = 3'h0, rx_fifo_event = 3'h0, rx_overrun_pulse, fifo = 3'h0;
  logic [15:0] ev_nak = 16'h0000, ev_ovr = 16'h0000, mk_rx = 16'h0000, mk_nak = 16'h0000;
  integer errors = 0, checks_done = 0, seed = 28974;
  always #12.5 clk_sys = ~clk_sys;
  unrem_top unrem_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .addr_enable(addr_enable),
    .endpoint_enable(endpoint_enable), .nak_sent(nak_sent), .nak_token_in(nak_token_in),
    .nak_endpoint(nak_endpoint), .nak_for_overrun(nak_for_overrun), .rx_overrun_pulse(rx_overrun_pulse),
    .rx_fifo_event(rx_fifo_event), .receive_summary_flag_q(receive_summary_flag_q),
    .nak_summary_flag_q(nak_summary_flag_q), .irq_q(irq_q));
  unrem_host_model unrem_host_model_i (.clk_sys(clk_sys), .nak_sent(nak_sent), .nak_token_in(nak_token_in),
    .nak_endpoint(nak_endpoint), .nak_for_overrun(nak_for_overrun), .rx_overrun_pulse(rx_overrun_pulse));
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge clk_sys);
    n++;
    if (n > 50) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v, output logic [1:0] r);
    int n;
    logic aw, w;
    n = 0;
    aw = 0;
    w = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= 32'(a);
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      tick(n);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do tick(n); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [ADDR_W-1:0] a, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= 32'(a);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do tick(n); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    rdr(a, rsp);
    `CHK(rsp, RESP_OKAY)
    `CHK(rd, 32'(e))
  endtask
  // The summary follows an event two edges later, so three edges leave margin.
  task automatic chk_sum;
    repeat (3) @(posedge clk_sys);
    `CHK(nak_summary_flag_q, |(ev_nak & mk_nak))
    `CHK(receive_summary_flag_q, |((ev_ovr | 16'(fifo)) & mk_rx))
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    chk_rd(ADR_RX_MASK, RST_REG);
    chk_rd(ADR_NAK_MASK, RST_REG);
    chk_rd(ADR_NAK_EVENT, RST_REG);
    d = $random(seed);
    wr(ADR_NAK_MASK, d, rsp);
    mk_nak = d[15:0] & EV_FIELDS;
    chk_rd(ADR_NAK_MASK, mk_nak);
    addr_enable <= 1'b1;
    endpoint_enable <= 3'h7;
    for (int ep = 1; ep <= 3; ep++) begin
      for (int t = 0; t < 2; t++) begin
        unrem_host_model_i.nak(t[0], ep[1:0], 1'b0);
        ev_nak = 16'h0001 << (ep - 1 + (t == 1 ? LO_LSB : HI_LSB));
        chk_sum();
        chk_rd(ADR_NAK_EVENT, ev_nak);
        ev_nak = 16'h0000;
        chk_rd(ADR_NAK_EVENT, ev_nak);
      end
    end
    addr_enable <= 1'b0;
    unrem_host_model_i.nak(1'b1, 2'h1, 1'b0);
    addr_enable <= 1'b1;
    endpoint_enable <= 3'h5;
    unrem_host_model_i.nak(1'b0, 2'h2, 1'b0);
    unrem_host_model_i.nak(1'b0, 2'h3, 1'b1);
    unrem_host_model_i.nak(1'b1, 2'h0, 1'b0);
    chk_rd(ADR_NAK_EVENT, ev_nak);
    repeat (4) begin
      d = $random(seed);
      wr(ADR_RX_MASK, d, rsp);
      mk_rx = d[15:0] & EV_FIELDS;
      chk_rd(ADR_RX_MASK, mk_rx);
      fifo = 3'($random(seed));
      rx_fifo_event <= fifo;
      d = $random(seed);
      unrem_host_model_i.overrun(d[2:0]);
      ev_ovr = 16'(d[2:0]) << HI_LSB;
      chk_sum();
      chk_rd(ADR_RX_EVENT, ev_ovr | 16'(fifo));
      ev_ovr = 16'h0000;
      chk_rd(ADR_RX_EVENT, 16'(fifo));
    end
    wr(ADR_NAK_MASK, 32'h0000_0077, rsp);
    mk_nak = 16'h0077;
    // Old sticky status from the earlier scenarios is cleared so the next rise is this event's own.
    wr(ADR_IRQ_STATUS, 32'h0000_0003, rsp);
    wr(ADR_IRQ_MASK, 32'h0000_0002, rsp);
    repeat (3) @(posedge clk_sys);
    `CHK(irq_q, 1'b0)
    unrem_host_model_i.nak(1'b1, 2'h3, 1'b0);
    ev_nak = 16'h0004;
    chk_sum();
    repeat (3) @(posedge clk_sys);
    `CHK(irq_q, 1'b1)
    wr(ADR_IRQ_MASK, 32'h0000_0000, rsp);
    repeat (3) @(posedge clk_sys);
    `CHK(irq_q, 1'b0)
    chk_rd(ADR_NAK_EVENT, ev_nak);
    ev_nak = 16'h0000;
    chk_sum();
    wr(ADR_IRQ_STATUS, 32'h0000_0003, rsp);
    wr(ADR_IRQ_MASK, 32'h0000_0002, rsp);
    repeat (3) @(posedge clk_sys);
    `CHK(irq_q, 1'b0)
    rdr(12'h0FC, rsp);
    `CHK(rsp, RESP_SLVERR)
    wr(ADR_NAK_EVENT, 32'h0000_FFFF, rsp);
    `CHK(rsp, RESP_SLVERR)
    tally_and_finish();
  end
endmodule
